//--- ufd_cfg.svh
// Register indices, field positions, reset values and widths of the USB device register block.
`ifndef UFD_CFG_SVH
`define UFD_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define UFD_IDX_W          10
`define UFD_IDX_DEVICE_ADDRESS_FIELD   10'h000
`define UFD_IDX_POWER      10'h001
`define UFD_IDX_IN_IRQ     10'h002
`define UFD_IDX_OUT_IRQ    10'h004
`define UFD_IDX_BUS_IRQ    10'h006
`define UFD_IDX_IN_EN      10'h007
`define UFD_IDX_OUT_EN     10'h009
`define UFD_IDX_BUS_EN     10'h00b
`define UFD_IDX_FRAME_LO   10'h00c
`define UFD_IDX_FRAME_HI   10'h00d
`define UFD_IDX_EP_SEL     10'h00e
`define UFD_IDX_IN_MAX     10'h010
`define UFD_IDX_CSR_A      10'h011
`define UFD_IDX_IN_CSR2    10'h012
`define UFD_IDX_OUT_MAX    10'h013
`define UFD_IDX_OUT_CSR1   10'h014
`define UFD_IDX_OUT_CSR2   10'h015
`define UFD_IDX_CNT_LO     10'h016
`define UFD_IDX_CNT_HI     10'h017
`define UFD_IDX_FIFO_LO    10'h020
`define UFD_IDX_FIFO_HI    10'h02f
`define UFD_IDX_DMA        10'h204

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UFD_RST_ZERO       8'h00
`define UFD_RST_IN_EN      8'hff
`define UFD_RST_OUT_EN     8'hfe
`define UFD_RST_BUS_EN     8'h06
`define UFD_RST_OUT_CSR1   8'h00

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define UFD_ADDR_PEND_BIT  7
`define UFD_PWR_ISO_BIT    7
`define UFD_PWR_RST_BIT    3
`define UFD_PWR_RES_BIT    2
`define UFD_PWR_SUS_BIT    1
`define UFD_PWR_SEN_BIT    0
`define UFD_CSR1_RDY_BIT   0
`define UFD_CSR2_ISO_BIT   6
`define UFD_BUS_PLUG_BIT   4
`define UFD_BUS_SOF_BIT    3
`define UFD_BUS_RST_BIT    2
`define UFD_BUS_RES_BIT    1
`define UFD_BUS_SUS_BIT    0
`define UFD_FRAME_W        11
`define UFD_MIN_ADDR_W     12

`endif

//--- ufd_pkg.sv
// Types shared by the USB device register block and its surroundings.
package ufd_pkg;

   // -------------------------------------------------------------------------
   // Answer kinds for an IN token
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      UFD_REPLY_NAK,
      UFD_REPLY_DATA,
      UFD_REPLY_ZLP
   } ufd_reply_kind_t;

   // -------------------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic        sof;
      logic [10:0] frame_no;
      logic        bus_reset;
      logic        suspend_det;
      logic        resume_det;
      logic        xfer_done;
      logic        plug_evt;
      logic        in_token;
      logic [1:0]  token_ep;
      logic [3:0]  in_ep_evt;
      logic [3:1]  out_ep_evt;
   } ufd_sie_evt_t;

   typedef struct packed {
      logic            valid;
      ufd_reply_kind_t kind;
      logic [1:0]      ep;
   } ufd_in_reply_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [1:0] ep;
      logic [7:0] wdata;
   } ufd_fifo_req_t;

endpackage : ufd_pkg

//--- ufd_regs_power.sv
// APB register block of the full-speed USB device: map, address update, power, IN frame wait.
`timescale 1ns/1ps
`include "ufd_cfg.svh"

module ufd_regs_power #(
   parameter int ADDR_W = 12
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [ADDR_W-1:0]      paddr,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   usb_dp_pin,
   input  wire logic                   usb_dm_pin,
   input  wire ufd_pkg::ufd_sie_evt_t  sie_evt,
   input  wire logic [7:0]             ep0_rx_count,
   input  wire logic [15:0]            out_fifo_count [1:3],
   input  wire logic [7:0]             fifo_rdata,
   output ufd_pkg::ufd_fifo_req_t      fifo_req,
   output ufd_pkg::ufd_in_reply_t      in_reply,
   output logic [6:0]                  device_address,
   output logic                        resume_drive,
   output logic                        suspend_state,
   output logic [7:0]                  dma_control,
   output logic                        irq
);
   import ufd_pkg::*;

   // -------------------------------------------------------------------------
   // Parameter check
   // -------------------------------------------------------------------------
   generate
      if (ADDR_W < `UFD_MIN_ADDR_W) begin : g_bad_addr_w
         $error("ADDR_W too small to reach the DMA control register");
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------------------
   function automatic logic idx_mapped(input logic [`UFD_IDX_W-1:0] i);
      if (i <= `UFD_IDX_EP_SEL) begin
         idx_mapped = (i != 10'h003) && (i != 10'h005) && (i != 10'h008) && (i != 10'h00a);
      end else if (i >= `UFD_IDX_IN_MAX && i <= `UFD_IDX_CNT_HI) begin
         idx_mapped = 1'b1;
      end else if (i >= `UFD_IDX_FIFO_LO && i <= `UFD_IDX_FIFO_HI) begin
         idx_mapped = 1'b1;
      end else begin
         idx_mapped = (i == `UFD_IDX_DMA);
      end
   endfunction : idx_mapped

   function automatic logic is_fifo(input logic [`UFD_IDX_W-1:0] i);
      is_fifo = (i >= `UFD_IDX_FIFO_LO) && (i <= `UFD_IDX_FIFO_HI);
   endfunction : is_fifo

   // -------------------------------------------------------------------------
   // APB handshake
   // -------------------------------------------------------------------------
   // One wait state lets read data come from a flip-flop.
   logic                   ack_r;
   logic [`UFD_IDX_W-1:0]  idx;
   logic                   wr_go;
   logic                   rd_go;
   logic [7:0]             wb;
   logic [7:0]             rd_mux;

   assign idx     = paddr[`UFD_IDX_W+1:2];
   assign pready  = psel & penable & ack_r;
   assign pslverr = pready & ~idx_mapped(idx);
   assign wr_go   = pready & pwrite & pstrb[0] & idx_mapped(idx);
   assign rd_go   = pready & ~pwrite & idx_mapped(idx);
   assign wb      = pwdata[7:0];

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= psel & penable & ~ack_r;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel & penable & ~ack_r & ~pwrite) begin
         prdata <= {24'h00_0000, rd_mux};
      end
   end

   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   logic [1:0] line_meta_r;
   logic [1:0] line_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         line_meta_r <= 2'b00;
         line_r      <= 2'b00;
      end else begin
         line_meta_r <= {usb_dp_pin, usb_dm_pin};
         line_r      <= line_meta_r;
      end
   end

   // -------------------------------------------------------------------------
   // Device address
   // -------------------------------------------------------------------------
   logic [6:0] addr_stage_r;
   logic       addr_pend_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         addr_stage_r   <= 7'h00;
         addr_pend_r    <= 1'b0;
         device_address <= 7'h00;
      end else begin
         if (wr_go && idx == `UFD_IDX_DEVICE_ADDRESS_FIELD) begin
            addr_stage_r <= wb[6:0];
            addr_pend_r  <= 1'b1;
         end else if (addr_pend_r && sie_evt.xfer_done) begin
            addr_pend_r    <= 1'b0;
            device_address <= addr_stage_r;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Power management
   // -------------------------------------------------------------------------
   logic iso_wait_r;
   logic resume_r;
   logic susp_en_r;
   logic bus_rd_go;
   logic resume_set;

   assign bus_rd_go  = rd_go && (idx == `UFD_IDX_BUS_IRQ);
   assign resume_set = wr_go && (idx == `UFD_IDX_POWER) && wb[`UFD_PWR_RES_BIT];

   always_ff @(posedge clk) begin
      if (rst) begin
         iso_wait_r <= 1'b0;
         resume_r   <= 1'b0;
         susp_en_r  <= 1'b0;
      end else if (wr_go && idx == `UFD_IDX_POWER) begin
         iso_wait_r <= wb[`UFD_PWR_ISO_BIT];
         resume_r   <= wb[`UFD_PWR_RES_BIT];
         susp_en_r  <= wb[`UFD_PWR_SEN_BIT];
      end
   end

   // Entry wins over a clearing read or resume write in the same cycle.
   always_ff @(posedge clk) begin
      if (rst) begin
         suspend_state <= 1'b0;
      end else if (sie_evt.suspend_det && susp_en_r) begin
         suspend_state <= 1'b1;
      end else if (bus_rd_go || resume_set) begin
         suspend_state <= 1'b0;
      end
   end

   // Resume drive starts only from suspend and ends when software clears the bit.
   always_ff @(posedge clk) begin
      if (rst) begin
         resume_drive <= 1'b0;
      end else if (resume_set && suspend_state) begin
         resume_drive <= 1'b1;
      end else if (!resume_r) begin
         resume_drive <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Interrupt status and enables
   // -------------------------------------------------------------------------
   logic [3:0] in_irq_r;
   logic [3:1] out_irq_r;
   logic [4:0] bus_irq_r;
   logic [7:0] in_en_r;
   logic [7:0] out_en_r;
   logic [7:0] bus_en_r;
   logic       bus_reset_q_r;
   logic [4:0] bus_set;
   logic [3:0] in_clr;
   logic [3:1] out_clr;
   logic [4:0] bus_clr;

   assign bus_set = {sie_evt.plug_evt, sie_evt.sof, sie_evt.bus_reset & ~bus_reset_q_r,
                     sie_evt.resume_det & suspend_state, sie_evt.suspend_det};

   // A read clears the flags held in its ready cycle, one cycle after its data was taken; a write of one clears too.
   always_comb begin
      in_clr  = 4'h0;
      out_clr = 3'h0;
      bus_clr = 5'h00;
      if (rd_go && idx == `UFD_IDX_IN_IRQ) begin
         in_clr = in_irq_r;
      end
      if (rd_go && idx == `UFD_IDX_OUT_IRQ) begin
         out_clr = out_irq_r;
      end
      if (bus_rd_go) begin
         bus_clr = bus_irq_r;
      end
      if (wr_go && idx == `UFD_IDX_IN_IRQ) begin
         in_clr = in_clr | wb[3:0];
      end
      if (wr_go && idx == `UFD_IDX_OUT_IRQ) begin
         out_clr = out_clr | wb[3:1];
      end
      if (wr_go && idx == `UFD_IDX_BUS_IRQ) begin
         bus_clr = bus_clr | wb[4:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         in_irq_r      <= 4'h0;
         out_irq_r     <= 3'h0;
         bus_irq_r     <= 5'h00;
         bus_reset_q_r <= 1'b0;
      end else begin
         in_irq_r      <= (in_irq_r & ~in_clr) | sie_evt.in_ep_evt;
         out_irq_r     <= (out_irq_r & ~out_clr) | sie_evt.out_ep_evt;
         bus_irq_r     <= (bus_irq_r & ~bus_clr) | bus_set;
         bus_reset_q_r <= sie_evt.bus_reset;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         in_en_r  <= `UFD_RST_IN_EN;
         out_en_r <= `UFD_RST_OUT_EN;
         bus_en_r <= `UFD_RST_BUS_EN;
      end else if (wr_go) begin
         if (idx == `UFD_IDX_IN_EN) begin
            in_en_r <= wb;
         end else if (idx == `UFD_IDX_OUT_EN) begin
            out_en_r <= wb;
         end else if (idx == `UFD_IDX_BUS_EN) begin
            bus_en_r <= wb;
         end
      end
   end

   assign irq = |(in_irq_r & in_en_r[3:0]) | |(out_irq_r & out_en_r[3:1]) |
                |(bus_irq_r & bus_en_r[4:0]);

   // -------------------------------------------------------------------------
   // Frame number, selector, DMA control
   // -------------------------------------------------------------------------
   logic [`UFD_FRAME_W-1:0] frame_r;
   logic [7:0]              sel_r;
   logic [1:0]              ep;

   assign ep = sel_r[1:0];

   always_ff @(posedge clk) begin
      if (rst) begin
         frame_r <= '0;
      end else if (sie_evt.sof) begin
         frame_r <= sie_evt.frame_no;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sel_r       <= `UFD_RST_ZERO;
         dma_control <= `UFD_RST_ZERO;
      end else if (wr_go) begin
         if (idx == `UFD_IDX_EP_SEL) begin
            sel_r <= wb;
         end else if (idx == `UFD_IDX_DMA) begin
            dma_control <= wb;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Indexed endpoint registers and IN frame wait
   // -------------------------------------------------------------------------
   logic [7:0] ctrl_ep_ctrl_status_r;
   logic [7:0] in_max_r  [1:3];
   logic [7:0] in_csr1_r [1:3];
   logic [7:0] in_csr2_r [1:3];
   logic [7:0] out_max_r [1:3];
   logic [7:0] out_csr1_r[1:3];
   logic [7:0] out_csr2_r[1:3];
   logic [3:1] sof_seen_r;
   logic [3:1] send_now;
   logic       sel_in_range;

   assign sel_in_range = (sel_r[7:2] == 6'h00) && (ep != 2'd0);

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_ep_ctrl_status_r <= `UFD_RST_ZERO;
      end else if (wr_go && idx == `UFD_IDX_CSR_A && sel_r == 8'h00) begin
         ctrl_ep_ctrl_status_r <= wb;
      end
   end

   genvar g;
   generate
      for (g = 1; g <= 3; g++) begin : g_ep
         logic sel_me;
         logic rdy_set;
         assign sel_me  = wr_go && sel_in_range && (ep == 2'(g));
         assign rdy_set = sel_me && (idx == `UFD_IDX_CSR_A) && wb[`UFD_CSR1_RDY_BIT];
         assign send_now[g] = sie_evt.in_token && (sie_evt.token_ep == 2'(g)) &&
                              in_csr1_r[g][`UFD_CSR1_RDY_BIT];

         always_ff @(posedge clk) begin
            if (rst) begin
               in_max_r[g]   <= `UFD_RST_ZERO;
               in_csr2_r[g]  <= `UFD_RST_ZERO;
               out_max_r[g]  <= `UFD_RST_ZERO;
               out_csr1_r[g] <= `UFD_RST_OUT_CSR1;
               out_csr2_r[g] <= `UFD_RST_ZERO;
            end else if (sel_me) begin
               if (idx == `UFD_IDX_IN_MAX) begin
                  in_max_r[g] <= wb;
               end else if (idx == `UFD_IDX_IN_CSR2) begin
                  in_csr2_r[g] <= wb;
               end else if (idx == `UFD_IDX_OUT_MAX) begin
                  out_max_r[g] <= wb;
               end else if (idx == `UFD_IDX_OUT_CSR1) begin
                  out_csr1_r[g] <= wb;
               end else if (idx == `UFD_IDX_OUT_CSR2) begin
                  out_csr2_r[g] <= wb;
               end
            end
         end

         // A software set of packet-ready wins over the clear that sending makes.
         always_ff @(posedge clk) begin
            if (rst) begin
               in_csr1_r[g] <= `UFD_RST_ZERO;
            end else if (sel_me && idx == `UFD_IDX_CSR_A) begin
               in_csr1_r[g] <= wb;
            end else if (send_now[g] && in_reply_kind_nxt(g) == UFD_REPLY_DATA) begin
               in_csr1_r[g][`UFD_CSR1_RDY_BIT] <= 1'b0;
            end
         end

         // Frame start seen since packet-ready was set; a new set restarts the wait.
         always_ff @(posedge clk) begin
            if (rst) begin
               sof_seen_r[g] <= 1'b0;
            end else if (rdy_set) begin
               sof_seen_r[g] <= 1'b0;
            end else if (sie_evt.sof) begin
               sof_seen_r[g] <= 1'b1;
            end
         end
      end
   endgenerate

   function automatic ufd_reply_kind_t in_reply_kind_nxt(input int e);
      logic waiting;
      waiting = iso_wait_r && in_csr2_r[e][`UFD_CSR2_ISO_BIT] && !sof_seen_r[e];
      if (!in_csr1_r[e][`UFD_CSR1_RDY_BIT]) begin
         in_reply_kind_nxt = UFD_REPLY_NAK;
      end else if (waiting) begin
         in_reply_kind_nxt = UFD_REPLY_ZLP;
      end else begin
         in_reply_kind_nxt = UFD_REPLY_DATA;
      end
   endfunction : in_reply_kind_nxt

   // Endpoint 0 always answers with data here; its handshake lives in the serial engine.
   always_ff @(posedge clk) begin
      if (rst) begin
         in_reply <= '0;
      end else begin
         in_reply.valid <= sie_evt.in_token;
         in_reply.ep    <= sie_evt.token_ep;
         if (sie_evt.token_ep == 2'd0) begin
            in_reply.kind <= UFD_REPLY_DATA;
         end else begin
            in_reply.kind <= in_reply_kind_nxt(int'(sie_evt.token_ep));
         end
      end
   end

   // -------------------------------------------------------------------------
   // FIFO window
   // -------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         fifo_req <= '0;
      end else begin
         fifo_req.wr    <= wr_go && is_fifo(idx);
         fifo_req.rd    <= rd_go && is_fifo(idx);
         fifo_req.ep    <= idx[1:0];
         fifo_req.wdata <= wb;
      end
   end

   // -------------------------------------------------------------------------
   // Read multiplexer
   // -------------------------------------------------------------------------
   always_comb begin
      rd_mux = 8'h00;
      if (idx == `UFD_IDX_DEVICE_ADDRESS_FIELD) begin
         rd_mux = {addr_pend_r, addr_stage_r};
      end else if (idx == `UFD_IDX_POWER) begin
         rd_mux = {iso_wait_r, 3'b000, sie_evt.bus_reset, resume_r, suspend_state,
                   susp_en_r};
      end else if (idx == `UFD_IDX_IN_IRQ) begin
         rd_mux = {4'h0, in_irq_r};
      end else if (idx == `UFD_IDX_OUT_IRQ) begin
         rd_mux = {4'h0, out_irq_r, 1'b0};
      end else if (idx == `UFD_IDX_BUS_IRQ) begin
         rd_mux = {line_r, 1'b0, bus_irq_r};
      end else if (idx == `UFD_IDX_IN_EN) begin
         rd_mux = in_en_r;
      end else if (idx == `UFD_IDX_OUT_EN) begin
         rd_mux = out_en_r;
      end else if (idx == `UFD_IDX_BUS_EN) begin
         rd_mux = bus_en_r;
      end else if (idx == `UFD_IDX_FRAME_LO) begin
         rd_mux = frame_r[7:0];
      end else if (idx == `UFD_IDX_FRAME_HI) begin
         rd_mux = {5'h00, frame_r[10:8]};
      end else if (idx == `UFD_IDX_EP_SEL) begin
         rd_mux = sel_r;
      end else if (idx == `UFD_IDX_CSR_A && sel_r == 8'h00) begin
         rd_mux = ctrl_ep_ctrl_status_r;
      end else if (idx == `UFD_IDX_CNT_LO && sel_r == 8'h00) begin
         rd_mux = ep0_rx_count;
      end else if (is_fifo(idx)) begin
         rd_mux = fifo_rdata;
      end else if (idx == `UFD_IDX_DMA) begin
         rd_mux = dma_control;
      end else if (sel_in_range) begin
         if (idx == `UFD_IDX_IN_MAX) begin
            rd_mux = in_max_r[ep];
         end else if (idx == `UFD_IDX_CSR_A) begin
            rd_mux = in_csr1_r[ep];
         end else if (idx == `UFD_IDX_IN_CSR2) begin
            rd_mux = in_csr2_r[ep];
         end else if (idx == `UFD_IDX_OUT_MAX) begin
            rd_mux = out_max_r[ep];
         end else if (idx == `UFD_IDX_OUT_CSR1) begin
            rd_mux = out_csr1_r[ep];
         end else if (idx == `UFD_IDX_OUT_CSR2) begin
            rd_mux = out_csr2_r[ep];
         end else if (idx == `UFD_IDX_CNT_LO) begin
            rd_mux = out_fifo_count[ep][7:0];
         end else if (idx == `UFD_IDX_CNT_HI) begin
            rd_mux = out_fifo_count[ep][15:8];
         end
      end
   end

endmodule : ufd_regs_power

//--- ufd_regs_power_sva.sv
// Port-level assertions for the USB device register block.
`timescale 1ns/1ps
module ufd_regs_power_sva #(
   parameter int ADDR_W = 12
) (
   input wire logic                   clk,
   input wire logic                   rst,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [ADDR_W-1:0]      paddr,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire ufd_pkg::ufd_sie_evt_t  sie_evt,
   input wire ufd_pkg::ufd_in_reply_t in_reply,
   input wire logic [6:0]             device_address,
   input wire logic                   resume_drive,
   input wire logic                   suspend_state
);
   import ufd_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire rd_pwr = pready && !pwrite && paddr[11:2] == 10'h001;
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_ack; pready |-> $past(psel && penable); endproperty
   a_ack: assert property (p_ack) else $error("ready without access");
   property p_hi; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_rstb; rd_pwr |-> prdata[3] == $past(sie_evt.bus_reset); endproperty
   a_rstb: assert property (p_rstb) else $error("bus reset bit wrong");
   property p_addr; $changed(device_address) |-> $past(sie_evt.xfer_done); endproperty
   a_addr: assert property (p_addr) else $error("address applied early");
   property p_sus; $rose(suspend_state) |-> $past(sie_evt.suspend_det); endproperty
   a_sus: assert property (p_sus) else $error("suspend without cause");
   property p_clr; $fell(suspend_state) |-> $past(pready); endproperty
   a_clr: assert property (p_clr) else $error("suspend cleared alone");
   property p_res; $rose(resume_drive) |-> $past(suspend_state && pready && pwrite); endproperty
   a_res: assert property (p_res) else $error("resume without cause");
   property p_rep; in_reply.valid |-> $past(sie_evt.in_token); endproperty
   a_rep: assert property (p_rep) else $error("reply without token");
   c_zlp: cover property (in_reply.valid && in_reply.kind == UFD_REPLY_ZLP);
   c_sus: cover property ($rose(suspend_state));
   c_err: cover property (pslverr);
endmodule : ufd_regs_power_sva

//--- ufd_host_model.sv
// Behavioural model of the bus events that the host side presents.
`timescale 1ns/1ps
module ufd_host_model (
   input  wire logic             clk,
   output ufd_pkg::ufd_sie_evt_t sie_evt
);
   import ufd_pkg::*;
   ufd_sie_evt_t ev_r    = '0;
   logic         bus_lvl = 1'b0;
   always_comb begin
      sie_evt = ev_r;
      sie_evt.bus_reset = bus_lvl;
   end
   // Bus reset is a line state, so it stays up until the host drops it.
   task automatic lvl(input logic v);
      @(posedge clk);
      bus_lvl <= v;
   endtask : lvl
   // Kinds: 0 suspend, 1 transfer end, 2 start of frame, 3 IN token.
   task automatic go(input int k, input logic [10:0] f);
      ufd_sie_evt_t e;
      e = '0;
      e.suspend_det = (k == 0);
      e.xfer_done = (k == 1);
      e.sof = (k == 2);
      e.in_token = (k == 3);
      e.frame_no = f;
      e.token_ep = f[1:0];
      @(posedge clk);
      ev_r <= e;
      @(posedge clk);
      ev_r <= '0;
   endtask : go
endmodule : ufd_host_model

//--- tb_top.sv
// Directed testbench for the USB device register block.
`timescale 1ns/1ps
`include "ufd_cfg.svh"
module tb_top;
   import ufd_pkg::*;
   logic          clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, e;
   logic [11:0]   paddr = '0;
   logic [31:0]   pwdata = '0, prdata;
   logic          pready, pslverr, resume_drive, suspend_state, irq;
   logic [15:0]   ocnt [1:3] = '{16'h0123, 16'h0456, 16'h0789};
   logic [6:0]    dev_a;
   logic [7:0]    q, dma, ep0c = 8'h5e, frd = 8'h3c;
   int            err_total = 0, comparisons = 0;
   ufd_sie_evt_t  sie;
   ufd_fifo_req_t freq;
   ufd_in_reply_t rep;
   always #2 clk = ~clk;
   ufd_regs_power i_ufd_regs_power (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .usb_dp_pin(1'b0), .usb_dm_pin(1'b0),
      .sie_evt(sie), .ep0_rx_count(ep0c), .out_fifo_count(ocnt), .fifo_rdata(frd),
      .fifo_req(freq), .in_reply(rep), .device_address(dev_a), .resume_drive(resume_drive),
      .suspend_state(suspend_state), .dma_control(dma), .irq(irq));
   ufd_host_model i_ufd_host_model (.clk(clk), .sie_evt(sie));
   task automatic test_done;
      if (err_total == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      comparisons++;
      if (g !== x) begin
         err_total++;
         $display("MISMATCH %0t got %h expected %h", $time, g, x);
      end
   endtask : chk
   // Ready, read data and error are taken at the rising edge that ends the access.
   task automatic acc(input logic w, input logic [9:0] i, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk(8'h00, 8'h01);
      if (n >= 20) test_done;
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : acc
   task automatic rd(input logic [9:0] i, input logic [7:0] x);
      acc(1'b0, i, 8'h00);
      chk(q, x);
   endtask : rd
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(`UFD_IDX_IN_EN, 8'hff);
      rd(`UFD_IDX_OUT_EN, 8'hfe);
      rd(`UFD_IDX_BUS_EN, 8'h06);
      rd(`UFD_IDX_BUS_IRQ, 8'h00);
      acc(1'b1, 10'h003, 8'h00);
      chk(e, 1'b1);
      acc(1'b1, `UFD_IDX_DEVICE_ADDRESS_FIELD, 8'h25);
      rd(`UFD_IDX_DEVICE_ADDRESS_FIELD, 8'ha5);
      chk(dev_a, 7'h00);
      i_ufd_host_model.go(1, 11'h0);
      rd(`UFD_IDX_DEVICE_ADDRESS_FIELD, 8'h25);
      chk(dev_a, 7'h25);
      acc(1'b1, `UFD_IDX_BUS_EN, 8'h01);
      i_ufd_host_model.go(0, 11'h0);
      rd(`UFD_IDX_POWER, 8'h00);
      acc(1'b1, `UFD_IDX_POWER, 8'h01);
      i_ufd_host_model.go(0, 11'h0);
      rd(`UFD_IDX_POWER, 8'h03);
      chk(irq, 1'b1);
      rd(`UFD_IDX_BUS_IRQ, 8'h01);
      chk(suspend_state, 1'b0);
      chk(irq, 1'b0);
      i_ufd_host_model.go(0, 11'h0);
      acc(1'b1, `UFD_IDX_POWER, 8'h05);
      chk(resume_drive, 1'b1);
      chk(suspend_state, 1'b0);
      acc(1'b1, `UFD_IDX_POWER, 8'h01);
      @(posedge clk);
      chk(resume_drive, 1'b0);
      i_ufd_host_model.lvl(1'b1);
      rd(`UFD_IDX_POWER, 8'h09);
      i_ufd_host_model.lvl(1'b0);
      rd(`UFD_IDX_POWER, 8'h01);
      i_ufd_host_model.go(2, 11'h5a3);
      rd(`UFD_IDX_FRAME_LO, 8'ha3);
      rd(`UFD_IDX_FRAME_HI, 8'h05);
      rd(10'h021, frd);
      chk(freq.rd, 1'b1);
      chk(freq.ep, 8'h01);
      acc(1'b1, `UFD_IDX_DMA, 8'h5a);
      chk(dma, 8'h5a);
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, `UFD_IDX_EP_SEL, i[7:0]);
         rd(`UFD_IDX_CNT_LO, i == 0 ? ep0c : ocnt[i][7:0]);
         rd(`UFD_IDX_CNT_HI, i == 0 ? 8'h00 : ocnt[i][15:8]);
      end
      acc(1'b1, `UFD_IDX_EP_SEL, 8'h01);
      acc(1'b1, `UFD_IDX_IN_CSR2, 8'h40);
      acc(1'b1, `UFD_IDX_POWER, 8'h81);
      acc(1'b1, `UFD_IDX_CSR_A, 8'h01);
      rd(`UFD_IDX_CSR_A, 8'h01);
      i_ufd_host_model.go(3, 11'h001);
      @(negedge clk);
      chk(rep.kind, UFD_REPLY_ZLP);
      i_ufd_host_model.go(2, 11'h002);
      i_ufd_host_model.go(3, 11'h001);
      @(negedge clk);
      chk(rep.kind, UFD_REPLY_DATA);
      test_done;
   end
endmodule : tb_top
bind ufd_regs_power ufd_regs_power_sva #(.ADDR_W(ADDR_W)) i_ufd_regs_power_sva (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sie_evt(sie_evt),
   .in_reply(in_reply), .device_address(device_address), .resume_drive(resume_drive),
   .suspend_state(suspend_state));
